// file: design/iip_port.sv
`include "iip_defs.svh"

module iip_port #(
  parameter int WIDTH    = 8,
  parameter int SCAN_DIV = `IIP_SCAN_DIV
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  input  wire logic [WIDTH-1:0] isolated_input_port,
  input  wire logic             supply_missing,
  input  wire logic             supply_low,
  output logic      [WIDTH-1:0] status_led,
  output logic                  irq
);

  // Three-stage synchronisers for field lines and supply monitors;
  // a level counts only once the second and third stages agree
  logic [WIDTH+1:0] sync1;
  logic [WIDTH+1:0] sync2;
  logic [WIDTH+1:0] sync3;
  logic [WIDTH+1:0] stable;
  wire  [WIDTH+1:0] raw_in = {supply_low, supply_missing, isolated_input_port};
  wire  [WIDTH+1:0] next_stable = (sync2 == sync3) ? sync3 : stable;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1  <= '0;
      sync2  <= '0;
      sync3  <= '0;
      stable <= '0;
    end else begin
      sync1  <= raw_in;
      sync2  <= sync1;
      sync3  <= sync2;
      stable <= next_stable;
    end
  end

  // Scan tick divider; one tick per filter sample, shared by all bits
  // so every line is sampled at the same instant
  logic [15:0] scan_cnt;
  wire         scan_tick = (scan_cnt == 16'(SCAN_DIV - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) scan_cnt <= 16'h0000;
    else if (scan_tick) scan_cnt <= 16'h0000;
    else scan_cnt <= scan_cnt + 16'h0001;
  end

  // Software-visible registers and the filtered port value
  iip_pkg::iip_ctrl_t ctrl;
  logic [WIDTH-1:0]   rise_mask;
  logic [WIDTH-1:0]   fall_mask;
  logic [WIDTH-1:0]   ref_pattern;
  logic [3:0]         status;
  logic [3:0]         irq_mask;
  logic [WIDTH-1:0]   rise_stat;
  logic [WIDTH-1:0]   fall_stat;
  wire  [WIDTH-1:0]   filtered;

  // Sample count for the chosen setting
  logic [10:0] n_sel;
  always_comb begin
    case (ctrl.filt)
      iip_pkg::IIP_FILT_10MS: n_sel = 11'(`IIP_N_10MS);
      iip_pkg::IIP_FILT_3MS2: n_sel = 11'(`IIP_N_3MS2);
      iip_pkg::IIP_FILT_1MS:  n_sel = 11'(`IIP_N_1MS);
      default:                n_sel = 11'h001;
    endcase
  end
  wire bypass = (ctrl.filt == iip_pkg::IIP_FILT_BYPASS);

  // Per-bit debounce counters; each line settles on its own, so one
  // bouncing contact cannot hold back the others
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_filt
      logic [10:0] cnt;
      logic        level_q;
      wire         differ = stable[gi] ^ level_q;
      wire         done   = (cnt + 11'h001 >= n_sel);
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt     <= 11'h000;
          level_q <= 1'b0;
        end else if (bypass) begin
          cnt     <= 11'h000;
          level_q <= stable[gi];
        end else if (!differ) begin
          cnt <= 11'h000;              // Any bounce restarts the count
        end else if (scan_tick) begin
          if (done) begin
            cnt     <= 11'h000;
            level_q <= stable[gi];
          end else begin
            cnt <= cnt + 11'h001;
          end
        end
      end
      assign filtered[gi] = level_q;   // One driver per bit of the port vector
    end
  endgenerate

  // Previous values; they reset to the reset levels of their sources,
  // so no false edge follows reset
  logic [WIDTH-1:0] filt_d;
  logic             match_d;
  logic             supply_low_d;
  logic             supply_miss_d;

  // Event decode; port events look only at filtered data
  wire [WIDTH-1:0] rise_ev  = filtered & ~filt_d & rise_mask;
  wire [WIDTH-1:0] fall_ev  = ~filtered & filt_d & fall_mask;
  wire             match    = (filtered == ref_pattern);
  wire             mode_on  = ctrl.irq_mode;
  wire             miss_lvl = stable[WIDTH];
  wire             low_lvl  = stable[WIDTH+1];

  // Status events; supplies fire on the flag rising, so a supply already
  // missing when interrupt mode is switched on goes unreported
  wire [3:0] ev;
  assign ev[`IIP_ST_EDGE] = mode_on & |(rise_ev | fall_ev);
  assign ev[`IIP_ST_PAT]  = mode_on & ctrl.pat_en & match & ~match_d;
  assign ev[`IIP_ST_MISS] = mode_on & ctrl.miss_en & miss_lvl & ~supply_miss_d;
  assign ev[`IIP_ST_LOW]  = mode_on & ctrl.low_en & low_lvl & ~supply_low_d;

  // Bus address phase capture; writes land one cycle later, in the
  // data phase, when hwdata is on the bus
  iip_pkg::iip_req_t req;
  logic              req_valid;
  wire               take     = hsel & hready & htrans[1];
  wire               wr_fire  = req_valid & req.write;
  wire               wr_ctrl  = wr_fire & (req.addr == `IIP_OFS_CTRL);
  wire               wr_rise  = wr_fire & (req.addr == `IIP_OFS_RISE);
  wire               wr_fall  = wr_fire & (req.addr == `IIP_OFS_FALL);
  wire               wr_pat   = wr_fire & (req.addr == `IIP_OFS_PATTERN);
  wire               wr_stat  = wr_fire & (req.addr == `IIP_OFS_STATUS);
  wire               wr_mask  = wr_fire & (req.addr == `IIP_OFS_MASK);
  wire               wr_rstat = wr_fire & (req.addr == `IIP_OFS_RSTAT);
  wire               wr_fstat = wr_fire & (req.addr == `IIP_OFS_FSTAT);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_valid <= 1'b0;
      req       <= '0;
    end else if (hready) begin
      req_valid <= take;
      req       <= '{addr: haddr[7:0], write: hwrite};
    end
  end

  // Write-one-to-clear masks; zero unless this cycle writes the
  // matching register
  wire [3:0]       clr_status = wr_stat  ? hwdata[3:0]       : 4'h0;
  wire [WIDTH-1:0] clr_rise   = wr_rstat ? hwdata[WIDTH-1:0] : '0;
  wire [WIDTH-1:0] clr_fall   = wr_fstat ? hwdata[WIDTH-1:0] : '0;

  // Sticky next values; a new event wins over a clear in the same cycle,
  // so software never loses an event it is acknowledging
  wire [3:0]       next_status    = ev | (status & ~clr_status);
  wire [WIDTH-1:0] next_rise_stat = (mode_on ? rise_ev : '0) | (rise_stat & ~clr_rise);
  wire [WIDTH-1:0] next_fall_stat = (mode_on ? fall_ev : '0) | (fall_stat & ~clr_fall);

  // Control word; reset selects the longest filter, the safest
  // setting for a port whose wiring is not yet known
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ctrl <= `IIP_CTRL_RESET;
    else if (wr_ctrl) ctrl <= hwdata[`IIP_CTRL_LOW_EN:`IIP_CTRL_FILT_LO];
  end

  // Edge masks, one bit per line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rise_mask <= '0;
    else if (wr_rise) rise_mask <= hwdata[WIDTH-1:0];
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) fall_mask <= '0;
    else if (wr_fall) fall_mask <= hwdata[WIDTH-1:0];
  end

  // Reference pattern; a new value takes effect on the next compare,
  // so writing the current input level raises a match event
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ref_pattern <= '0;
    else if (wr_pat) ref_pattern <= hwdata[WIDTH-1:0];
  end

  // Interrupt mask, same layout as status; masking hides a flag from
  // the line but leaves the flag itself readable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) irq_mask <= 4'h0;
    else if (wr_mask) irq_mask <= hwdata[3:0];
  end

  // Status flags; they stay set until software writes a one, so a
  // short event is not missed between two polls
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) status <= 4'h0;
    else status <= next_status;
  end

  // Per-bit edge reports
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rise_stat <= '0;
    else rise_stat <= next_rise_stat;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) fall_stat <= '0;
    else fall_stat <= next_fall_stat;
  end

  // Edge and match history; the match history only tracks while compare
  // is enabled, so enabling it on a matching port raises one event
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt_d  <= '0;
      match_d <= 1'b0;
    end else begin
      filt_d  <= filtered;
      match_d <= match & ctrl.pat_en;
    end
  end

  // Supply flag history; tracks even with interrupts off, so enabling
  // the mode later does not replay an old supply fault
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      supply_low_d  <= 1'b0;
      supply_miss_d <= 1'b0;
    end else begin
      supply_low_d  <= low_lvl;
      supply_miss_d <= miss_lvl;
    end
  end

  // Read mux on the address phase; unmapped offsets read zero. A read
  // issued during a write's data phase sees the old register value
  logic [31:0] rdata_mux;
  always_comb begin
    case (haddr[7:0])
      `IIP_OFS_DATA:    rdata_mux = 32'(filtered);
      `IIP_OFS_CTRL:    rdata_mux = 32'(ctrl);
      `IIP_OFS_RISE:    rdata_mux = 32'(rise_mask);
      `IIP_OFS_FALL:    rdata_mux = 32'(fall_mask);
      `IIP_OFS_PATTERN: rdata_mux = 32'(ref_pattern);
      `IIP_OFS_STATUS:  rdata_mux = 32'(status);
      `IIP_OFS_MASK:    rdata_mux = 32'(irq_mask);
      `IIP_OFS_RSTAT:   rdata_mux = 32'(rise_stat);
      `IIP_OFS_FSTAT:   rdata_mux = 32'(fall_stat);
      default:          rdata_mux = 32'h00000000;
    endcase
  end

  // Bus outputs; zero-wait slave, read data latched at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      if (take & ~hwrite) hrdata <= rdata_mux;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Port outputs; irq is built from the next status so it rises in the
  // same cycle as the flag instead of one cycle behind it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_led <= '0;
      irq        <= 1'b0;
    end else begin
      status_led <= filtered;
      irq        <= |(next_status & irq_mask);
    end
  end

  // Bus fields this slave has no use for
  wire unused_ok = |{hsize, haddr[31:8], htrans[0], hwdata[31:8]};

endmodule // iip_port

// file: common/iip_defs.svh
`ifndef IIP_DEFS_SVH
`define IIP_DEFS_SVH

// Register byte offsets
`define IIP_OFS_DATA     8'h00
`define IIP_OFS_CTRL     8'h04
`define IIP_OFS_RISE     8'h08
`define IIP_OFS_FALL     8'h0c
`define IIP_OFS_PATTERN  8'h10
`define IIP_OFS_STATUS   8'h14
`define IIP_OFS_MASK     8'h18
`define IIP_OFS_RSTAT    8'h1c
`define IIP_OFS_FSTAT    8'h20

// Control fields
`define IIP_CTRL_FILT_LO  0
`define IIP_CTRL_FILT_HI  1
`define IIP_CTRL_IRQ_MODE 2
`define IIP_CTRL_PAT_EN   3
`define IIP_CTRL_MISS_EN  4
`define IIP_CTRL_LOW_EN   5
`define IIP_CTRL_RESET    6'h00

// Status bit positions
`define IIP_ST_EDGE  0
`define IIP_ST_PAT   1
`define IIP_ST_MISS  2
`define IIP_ST_LOW   3

// Timing
`define IIP_CLK_HZ   200000000
`define IIP_SCAN_HZ  100000
`define IIP_SCAN_DIV (`IIP_CLK_HZ / `IIP_SCAN_HZ)
`define IIP_N_10MS   1248
`define IIP_N_3MS2   400
`define IIP_N_1MS    125

`endif

// file: common/iip_pkg.sv
package iip_pkg;
  typedef enum logic [1:0] {
    IIP_FILT_10MS  = 2'h0,
    IIP_FILT_3MS2  = 2'h1,
    IIP_FILT_1MS   = 2'h2,
    IIP_FILT_BYPASS = 2'h3
  } iip_filt_t;

  typedef enum logic [1:0] {
    IIP_IDLE = 2'h1,
    IIP_DATA = 2'h2
  } iip_phase_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       write;
  } iip_req_t;

  typedef struct packed {
    logic low_en;
    logic miss_en;
    logic pat_en;
    logic irq_mode;
    logic [1:0] filt;
  } iip_ctrl_t;
endpackage

// file: bench/iip_field.sv
module iip_field (
  input  wire logic       hclk,
  input  wire logic [7:0] level,
  input  wire logic       chatter,
  input  wire logic [1:0] supply,
  output logic      [7:0] port,
  output logic            miss,
  output logic            low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] phase = 3'h0;
  initial port = 8'h00;
  // Bouncing contacts flip every line each eighth cycle, slow enough to
  // pass the synchroniser and fast enough to keep the filter counting
  always @(posedge hclk) begin
    phase <= phase + 3'h1;
    if (!chatter) port <= level;
    else if (phase == 3'h7) port <= ~port;
  end
  // Comparators, high below threshold
  assign miss = supply[0];
  assign low  = supply[1];
endmodule // iip_field

// file: bench/iip_port_props.sv
`include "iip_defs.svh"
module iip_port_props (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        supply_missing,
  input wire logic        supply_low,
  input wire logic [7:0]  status_led,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       wr_q;
  logic [7:0] a_q;
  logic [5:0] ctrl_q;
  logic [3:0] mask_q;
  wire        rd_take = hsel && hready && htrans[1] && !hwrite;
  // Shadow of the event gating, only what writes tell us
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      a_q    <= 8'h00;
      ctrl_q <= 6'h00;
      mask_q <= 4'h0;
    end else begin
      wr_q <= hsel && hready && htrans[1] && hwrite;
      a_q  <= haddr[7:0];
      if (wr_q && a_q == `IIP_OFS_CTRL) ctrl_q <= hwdata[5:0];
      if (wr_q && a_q == `IIP_OFS_MASK) mask_q <= hwdata[3:0];
    end
  end
  AST_READY: assert property (hreadyout) else $error("wait state inserted");
  AST_RESP: assert property (!hresp) else $error("error response");
  AST_LED_RST: assert property ($rose(hresetn) |-> status_led == 8'h00)
    else $error("leds not clear after reset");
  AST_IRQ_RST: assert property ($rose(hresetn) |-> !irq)
    else $error("irq after reset");
  AST_DATA: assert property (rd_take && haddr[7:0] == `IIP_OFS_DATA
    |=> hrdata == {24'h0, status_led}) else $error("data read differs from leds");
  AST_UNMAP: assert property (rd_take && haddr[7:0] == 8'h40 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_HOLD: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data changed without a read");
  AST_MISS: assert property ($rose(supply_missing) && ctrl_q[2] && ctrl_q[4]
    && mask_q[2] |-> ##[1:12] irq) else $error("no supply missing irq");
  AST_LOW: assert property ($rose(supply_low) && ctrl_q[2] && ctrl_q[5]
    && mask_q[3] |-> ##[1:12] irq) else $error("no supply low irq");
endmodule // iip_port_props
bind iip_port iip_port_props iip_port_props_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .supply_missing, .supply_low,
  .status_led, .irq);

// file: bench/tb_isolated_input_port_events.sv
`include "iip_defs.svh"
module tb_isolated_input_port_events;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 4;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic        hready, hresp, miss, low, irq, chatter = 1'b0;
  logic [7:0]  level = 8'h00;
  logic [7:0]  port, led;
  logic [1:0]  supply = 2'h0;
  int          n_errors = 0;
  int          n_tests = 0;
  // Short scan divider keeps the long filter counts affordable
  iip_port #(.SCAN_DIV(DIV)) iip_port_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .isolated_input_port(port), .supply_missing(miss), .supply_low(low),
    .status_led(led), .irq(irq));
  iip_field iip_field_inst (.hclk(hclk), .level(level), .chatter(chatter), .supply(supply),
    .port(port), .miss(miss), .low(low));
  initial begin
    forever #2.5 hclk = ~hclk;
  end
  task automatic print_verdict();
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded wait for hready at a rising edge
  task automatic rdy();
    int i;
    i = 0;
    @(posedge hclk);
    while (hready !== 1'b1 && i < 50) begin
      @(posedge hclk);
      i++;
    end
    if (i == 50) begin
      n_errors++;
      print_verdict();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic t_filt();
    int n [3] = '{1248, 400, 125};
    logic [7:0] v [4] = '{8'h00, 8'h5a, 8'hc3, 8'h3c};
    rdc(`IIP_OFS_CTRL, 32'h0);
    rdc(8'h40, 32'h0);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, `IIP_OFS_CTRL, 32'(i));
      level <= v[i+1];
      repeat (n[i] * DIV - 40) @(posedge hclk);
      chk(32'(led), 32'(v[i]));
      repeat (80) @(posedge hclk);
      chk(32'(led), 32'(v[i+1]));
      rdc(`IIP_OFS_DATA, 32'(v[i+1]));
    end
    // Chatter shorter than the filter must not pass
    chatter <= 1'b1;
    repeat (200) @(posedge hclk);
    chatter <= 1'b0;
    chk(32'(led), 32'h3c);
    bus(1'b1, `IIP_OFS_CTRL, 32'h3);
    level <= 8'h81;
    repeat (12) @(posedge hclk);
    chk(32'(led), 32'h81);
  endtask
  task automatic t_irq();
    level <= 8'h02;
    bus(1'b1, `IIP_OFS_FALL, 32'h2);
    bus(1'b1, `IIP_OFS_RISE, 32'h1);
    bus(1'b1, `IIP_OFS_PATTERN, 32'h1);
    bus(1'b1, `IIP_OFS_MASK, 32'hf);
    bus(1'b1, `IIP_OFS_CTRL, 32'h3f);
    level <= 8'h01;
    repeat (12) @(posedge hclk);
    chk(32'(irq), 32'h1);
    rdc(`IIP_OFS_STATUS, 32'h3);
    rdc(`IIP_OFS_RSTAT, 32'h1);
    rdc(`IIP_OFS_FSTAT, 32'h2);
    bus(1'b1, `IIP_OFS_STATUS, 32'h3);
    rdc(`IIP_OFS_STATUS, 32'h0);
    chk(32'(irq), 32'h0);
    supply <= 2'h3;
    repeat (12) @(posedge hclk);
    rdc(`IIP_OFS_STATUS, 32'hc);
    bus(1'b1, `IIP_OFS_MASK, 32'h3);
    repeat (2) @(posedge hclk);
    chk(32'(irq), 32'h0);
    bus(1'b1, `IIP_OFS_STATUS, 32'hc);
    bus(1'b1, `IIP_OFS_RSTAT, 32'hff);
    bus(1'b1, `IIP_OFS_FSTAT, 32'hff);
    rdc(`IIP_OFS_RSTAT, 32'h0);
    bus(1'b1, `IIP_OFS_CTRL, 32'h3b);
    supply <= 2'h0;
    level <= 8'h02;
    repeat (12) @(posedge hclk);
    // Enabled edges, a match and supply faults with interrupt mode off
    supply <= 2'h3;
    level <= 8'h01;
    repeat (12) @(posedge hclk);
    rdc(`IIP_OFS_STATUS, 32'h0);
    rdc(`IIP_OFS_RSTAT, 32'h0);
    rdc(`IIP_OFS_FSTAT, 32'h0);
    chk(32'(irq), 32'h0);
  endtask
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_filt();
    t_irq();
    print_verdict();
  end
endmodule // tb_isolated_input_port_events
